// [fcic_consts.svh]
// constants of the framer control and interrupt hierarchy block
`ifndef FCIC_CONSTS_SVH
`define FCIC_CONSTS_SVH

`define FCIC_NUM_FRAMERS 8
`define FCIC_ADDR_W 12
`define FCIC_OFF_W 9
`define FCIC_FSEL_MSB 11
`define FCIC_FSEL_LSB 9

`define FCIC_OFF_CR0 9'h001
`define FCIC_OFF_IRR 9'h003
`define FCIC_OFF_ISR_FIRST 9'h004
`define FCIC_OFF_ISR_LAST 9'h00B
`define FCIC_OFF_IER_FIRST 9'h00C
`define FCIC_OFF_IER_LAST 9'h013
`define FCIC_OFF_FCR 9'h080
`define FCIC_OFF_MIR 9'h081
`define FCIC_OFF_MIE 9'h082
`define FCIC_OFF_TEST 9'h083

`define FCIC_FCR_GLOBAL_RESET_BIT_BIT 7
`define FCIC_FCR_ONESEC_BIT 2
`define FCIC_CR0_RESET_BIT 7
`define FCIC_CR0_INCF_BIT 5
`define FCIC_CR0_MODE_MSB 4
`define FCIC_CR0_MODE_LSB 1
`define FCIC_CR0_RATE_BIT 0
`define FCIC_TEST_BIT 1

`define FCIC_CR0_RESET 8'h00
`define FCIC_FCR_RESET 8'h00
`define FCIC_MIE_RESET 8'h00
`define FCIC_TEST_RESET 8'h00
`define FCIC_IER_RESET 8'h00

`define FCIC_RESET_TIME_NS 15000
`define FCIC_CLOCK_PERIOD_NS 20
`define FCIC_RESET_CYCLES (`FCIC_RESET_TIME_NS / `FCIC_CLOCK_PERIOD_NS)
`define FCIC_CNT_W 10

`endif

// [fcic_host.sv]
// host processor model driving the register port
`timescale 1ns/10ps
module fcic_host (
	input wire logic i_clock,
	input wire logic [7:0] i_rdata,
	output fcic_pkg::fcic_bus_t o_bus
);
	import fcic_pkg::*;
	initial o_bus = '{addr: 12'h000, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
	task automatic access(input logic [11:0] a, input logic [7:0] d,
		input logic w, output logic [7:0] q);
		@(posedge i_clock);
		#1;
		o_bus = '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge i_clock);
		#1;
		q = i_rdata;
		// released lines show no stale value
		o_bus = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] q;
		access(a, d, 1'b1, q);
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] q);
		access(a, 8'h00, 1'b0, q);
	endtask
	// no control write until the reset bit reads zero
	task automatic wait_idle(input logic [11:0] a, output int n);
		logic [7:0] q;
		n = 0;
		q = 8'h80;
		while (q[7] && n < 800) begin
			rd(a, q);
			n++;
		end
	endtask
endmodule // fcic_host

// [fcic_pkg.sv]
// types of the framer control and interrupt hierarchy block
package fcic_pkg;
`include "fcic_consts.svh"

	typedef enum logic [3:0] {
		FCIC_T1_NONE,
		FCIC_T1_FT_ONLY,
		FCIC_T1_ESF_FPS,
		FCIC_T1_SF,
		FCIC_T1_SF_JAPANESE_YELLOW,
		FCIC_T1_SF_DATA_MUX,
		FCIC_T1_LOOP_FRAME_SLIP_LOSS,
		FCIC_T1_LOOP_CARRIER,
		FCIC_T1_ESF_MIMIC_CRC,
		FCIC_T1_ESF_FORCE_CRC,
		FCIC_T1_RESERVED
	} fcic_t1_mode_t;

	typedef struct packed {
		logic line_rate_select;
		logic crc_fbit_real;
		logic [3:0] rx_framer_mode;
		logic e1_crc;
		logic e1_cas;
		logic bit_slip_search;
		fcic_t1_mode_t t1_mode;
	} fcic_cfg_t;

	typedef struct packed {
		logic [`FCIC_ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} fcic_bus_t;

	// [framer][request bit][status bit]
	typedef logic [`FCIC_NUM_FRAMERS-1:0][7:0][7:0] fcic_events_t;
endpackage

// [fcic_top.sv]
// framer control, framer reset and interrupt request hierarchy
//
// How it works
// R1 - two bits pick shared or separate bus groups
// R2 - master request latches on any framer request
// R3 - master enable gates request into master and pin
// R4 - eight framer bits, bit n is framer n
// R5 - framer reset bit starts bounded default reset
// R6 - reset bit reads one until reset completes
// R7 - host avoids control writes during reset
// R8 - power-up, global reset, pin also reset framers
// R9 - after reset outputs tristate, control and enable registers default; status and request bits keep their values, except that i_sys_rst clears them
// R10 - T1 CRC6 uses one or real F-bit
// R11 - E1 mode upper bits select CRC, CAS, BIT_SLIP_SEARCH
// R12 - T1 mode codes select framing format
// R13 - mode field also sets loss criteria
// R14 - rate bit selects E1 or T1 nominal
// R15 - host rewrites controls after rate change
// R16 - enabled status event latches request bit
// R17 - status read clears request bit, set wins
// R18 - request bits ORed into master request
// R19 - host confirms request register reads zero
// R20 - request bits map eight status registers
// R21 - status read clears latched status bits
// R22 - global reset bit resets globals and framers
// R23 - interrupt pin low while any master request
`timescale 1ns/10ps
`include "fcic_consts.svh"

module fcic_top (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_rst_pin_n,
	input wire fcic_pkg::fcic_bus_t i_bus,
	input wire fcic_pkg::fcic_events_t i_events,
	output logic [7:0] o_rdata,
	output logic o_interrupt_pin_n,
	output logic [1:0] o_bus_group_mode,
	output logic o_onesec_output,
	output logic o_test_enable,
	output logic [`FCIC_NUM_FRAMERS-1:0] o_sysbus_oe_n,
	output logic [`FCIC_NUM_FRAMERS-1:0] o_pio_oe_n,
	output logic [`FCIC_NUM_FRAMERS-1:0] o_reset_busy,
	output fcic_pkg::fcic_cfg_t [`FCIC_NUM_FRAMERS-1:0] o_cfg
);
	import fcic_pkg::*;

	localparam int NF = `FCIC_NUM_FRAMERS;
	localparam logic [`FCIC_CNT_W-1:0] LAST_CNT =
		`FCIC_CNT_W'(`FCIC_RESET_CYCLES - 1);

	function automatic logic in_range(input logic [8:0] a,
		input logic [8:0] lo, input logic [8:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction
	// request bit b summarises status register at last offset minus b
	function automatic logic [8:0] isr_off(input int b);
		isr_off = `FCIC_OFF_ISR_LAST - 9'(b);
	endfunction
	function automatic logic [8:0] ier_off(input int b);
		ier_off = `FCIC_OFF_IER_LAST - 9'(b);
	endfunction
	function automatic fcic_cfg_t cfg_decode(input logic rate,
		input logic incf, input logic [3:0] mode);
		fcic_cfg_t c;
		c = '0;
		c.line_rate_select = rate; // R14
		c.rx_framer_mode = mode; // R13
		c.crc_fbit_real = rate & incf; // R10
		c.e1_crc = !rate & mode[2]; // R11
		c.e1_cas = !rate & mode[3]; // R11
		c.bit_slip_search = !rate & mode[1]; // R11
		c.t1_mode = FCIC_T1_NONE;
		if (rate) begin
			case (mode) // R12
				4'h0: c.t1_mode = FCIC_T1_FT_ONLY;
				4'h1: c.t1_mode = FCIC_T1_ESF_FPS;
				4'h4: c.t1_mode = FCIC_T1_SF;
				4'h5: c.t1_mode = FCIC_T1_SF_JAPANESE_YELLOW;
				4'h6: c.t1_mode = FCIC_T1_SF_DATA_MUX;
				4'h8: c.t1_mode = FCIC_T1_LOOP_FRAME_SLIP_LOSS;
				4'h9: c.t1_mode = FCIC_T1_LOOP_CARRIER;
				4'hC: c.t1_mode = FCIC_T1_ESF_MIMIC_CRC;
				4'hD: c.t1_mode = FCIC_T1_ESF_FORCE_CRC;
				default: c.t1_mode = FCIC_T1_RESERVED;
			endcase
		end
		return c;
	endfunction

	wire logic [2:0] fsel = i_bus.addr[`FCIC_FSEL_MSB:`FCIC_FSEL_LSB];
	wire logic [8:0] off = i_bus.addr[`FCIC_OFF_W-1:0];
	wire logic g_wr = i_bus.wr && (fsel == 3'h0);
	wire logic g_rd = i_bus.rd && (fsel == 3'h0);

	// reset pin synchroniser
	logic pin_s1_q;
	logic pin_s2_q;
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
		end else begin
			pin_s1_q <= i_rst_pin_n;
			pin_s2_q <= pin_s1_q;
		end
	end
	wire logic pin_reset = !pin_s2_q;

	// global registers and global reset
	logic global_reset_bit_busy_q;
	logic [`FCIC_CNT_W-1:0] global_reset_bit_cnt_q;
	logic [1:0] group_mode_q;
	logic onesec_q;
	logic [7:0] mie_q;
	logic test_q;
	wire logic global_reset_bit_start = g_wr && (off == `FCIC_OFF_FCR) &&
		i_bus.wdata[`FCIC_FCR_GLOBAL_RESET_BIT_BIT] && !global_reset_bit_busy_q;
	wire logic g_hold = global_reset_bit_busy_q || global_reset_bit_start || pin_reset;

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			global_reset_bit_busy_q <= 1'b1;
			global_reset_bit_cnt_q <= '0;
		end else if (pin_reset || global_reset_bit_start) begin // R8 R22
			global_reset_bit_busy_q <= 1'b1;
			global_reset_bit_cnt_q <= '0;
		end else if (global_reset_bit_busy_q) begin
			global_reset_bit_busy_q <= (global_reset_bit_cnt_q != LAST_CNT);
			global_reset_bit_cnt_q <= global_reset_bit_cnt_q + `FCIC_CNT_W'(1);
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			group_mode_q <= 2'(`FCIC_FCR_RESET);
			onesec_q <= 1'b0;
			mie_q <= `FCIC_MIE_RESET;
			test_q <= 1'b0;
		end else if (g_hold) begin // R22
			group_mode_q <= 2'h0;
			onesec_q <= 1'b0;
			mie_q <= `FCIC_MIE_RESET;
			test_q <= 1'b0;
		end else if (g_wr) begin
			if (off == `FCIC_OFF_FCR) begin
				group_mode_q <= i_bus.wdata[1:0]; // R1
				onesec_q <= i_bus.wdata[`FCIC_FCR_ONESEC_BIT];
			end
			if (off == `FCIC_OFF_MIE)
				mie_q <= i_bus.wdata; // R3 R4
			if (off == `FCIC_OFF_TEST)
				test_q <= i_bus.wdata[`FCIC_TEST_BIT];
		end
	end

	// per framer state
	logic busy_q [NF];
	logic [`FCIC_CNT_W-1:0] cnt_q [NF];
	logic rate_q [NF];
	logic incf_q [NF];
	logic [3:0] mode_q [NF];
	logic oe_n_q [NF];
	fcic_cfg_t cfg_q [NF];
	logic [7:0] isr_q [NF][8];
	logic [7:0] ier_q [NF][8];
	logic irr_q [NF][8];
	logic [7:0] irr_vec [NF];
	logic [7:0] mir_d;
	logic [7:0] mir_q;

	for (genvar f = 0; f < NF; f++) begin : g_fr
		localparam logic [2:0] FID = 3'(f);
		wire logic fr_wr = i_bus.wr && (fsel == FID);
		wire logic fr_rd = i_bus.rd && (fsel == FID);
		wire logic cr0_hit = fr_wr && (off == `FCIC_OFF_CR0);
		// writes during reset are dropped
		wire logic cr0_wr = cr0_hit && !busy_q[f]; // R7
		wire logic start = (cr0_wr && i_bus.wdata[`FCIC_CR0_RESET_BIT]) ||
			global_reset_bit_start || pin_reset; // R5 R8
		wire logic hold = busy_q[f] || start;
		always_ff @(posedge i_clock or posedge i_sys_rst) begin
			if (i_sys_rst) begin
				busy_q[f] <= 1'b1;
				cnt_q[f] <= '0;
			end else if (start) begin
				busy_q[f] <= 1'b1; // R6
				cnt_q[f] <= '0;
			end else if (busy_q[f]) begin
				busy_q[f] <= (cnt_q[f] != LAST_CNT); // R5 R6
				cnt_q[f] <= cnt_q[f] + `FCIC_CNT_W'(1);
			end
		end
		always_ff @(posedge i_clock or posedge i_sys_rst) begin
			if (i_sys_rst) begin
				rate_q[f] <= 1'b0;
				incf_q[f] <= 1'b0;
				mode_q[f] <= 4'h0;
				oe_n_q[f] <= 1'b1;
			end else if (hold) begin // R9
				rate_q[f] <= 1'(`FCIC_CR0_RESET);
				incf_q[f] <= 1'b0;
				mode_q[f] <= 4'h0;
				oe_n_q[f] <= 1'b1;
			end else if (cr0_wr) begin
				rate_q[f] <= i_bus.wdata[`FCIC_CR0_RATE_BIT]; // R14
				incf_q[f] <= i_bus.wdata[`FCIC_CR0_INCF_BIT];
				mode_q[f] <= i_bus.wdata[`FCIC_CR0_MODE_MSB:`FCIC_CR0_MODE_LSB];
				oe_n_q[f] <= 1'b0;
			end
		end
		always_ff @(posedge i_clock or posedge i_sys_rst) begin
			if (i_sys_rst)
				cfg_q[f] <= '0;
			else
				cfg_q[f] <= cfg_decode(rate_q[f], incf_q[f], mode_q[f]);
		end
		for (genvar b = 0; b < 8; b++) begin : g_src
			wire logic clr = fr_rd && (off == isr_off(b));
			wire logic ier_wr = fr_wr && (off == ier_off(b)) && !busy_q[f];
			wire logic req = |(i_events[f][b] & ier_q[f][b]);
			always_ff @(posedge i_clock or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					isr_q[f][b] <= 8'h00;
					irr_q[f][b] <= 1'b0;
				end else begin
					isr_q[f][b] <= (clr ? 8'h00 : isr_q[f][b]) |
						i_events[f][b]; // R21
					irr_q[f][b] <= (irr_q[f][b] && !clr) || req; // R16 R17
				end
			end
			always_ff @(posedge i_clock or posedge i_sys_rst) begin
				if (i_sys_rst)
					ier_q[f][b] <= `FCIC_IER_RESET;
				else if (hold)
					ier_q[f][b] <= `FCIC_IER_RESET;
				else if (ier_wr)
					ier_q[f][b] <= i_bus.wdata;
			end
			assign irr_vec[f][b] = irr_q[f][b]; // R20
		end

		assign mir_d[f] = (|irr_vec[f]) && mie_q[f]; // R2 R3 R18
		assign o_sysbus_oe_n[f] = oe_n_q[f];
		assign o_pio_oe_n[f] = oe_n_q[f];
		assign o_reset_busy[f] = busy_q[f];
		assign o_cfg[f] = cfg_q[f];
	end

	logic interrupt_pin_n_n_q;
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			mir_q <= 8'h00;
			interrupt_pin_n_n_q <= 1'b1;
		end else begin
			mir_q <= mir_d; // R2 R4
			interrupt_pin_n_n_q <= ~(|mir_q); // R23
		end
	end

	// read mux
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	wire logic hit_isr = in_range(off, `FCIC_OFF_ISR_FIRST, `FCIC_OFF_ISR_LAST);
	wire logic hit_ier = in_range(off, `FCIC_OFF_IER_FIRST, `FCIC_OFF_IER_LAST);
	wire logic [2:0] isr_idx = 3'(`FCIC_OFF_ISR_LAST - off);
	wire logic [2:0] ier_idx = 3'(`FCIC_OFF_IER_LAST - off);
	always_comb begin
		if (g_rd && off == `FCIC_OFF_FCR)
			rdata_d = {global_reset_bit_busy_q, 4'h0, onesec_q, group_mode_q};
		else if (g_rd && off == `FCIC_OFF_MIR)
			rdata_d = mir_q;
		else if (g_rd && off == `FCIC_OFF_MIE)
			rdata_d = mie_q;
		else if (g_rd && off == `FCIC_OFF_TEST)
			rdata_d = {6'h00, test_q, 1'b0};
		else if (off == `FCIC_OFF_CR0)
			rdata_d = {busy_q[fsel], 1'b0, incf_q[fsel], mode_q[fsel],
				rate_q[fsel]}; // R6
		else if (off == `FCIC_OFF_IRR)
			rdata_d = irr_vec[fsel];
		else if (hit_isr)
			rdata_d = isr_q[fsel][isr_idx];
		else if (hit_ier)
			rdata_d = ier_q[fsel][ier_idx];
		else
			rdata_d = 8'h00;
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst)
			rdata_q <= 8'h00;
		else if (i_bus.rd)
			rdata_q <= rdata_d;
	end

	assign o_rdata = rdata_q;
	assign o_interrupt_pin_n = interrupt_pin_n_n_q;
	assign o_bus_group_mode = group_mode_q;
	assign o_onesec_output = onesec_q;
	assign o_test_enable = test_q;

	// checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	wire logic f0_cr0_reset_wr = i_bus.wr && fsel == 3'h0 &&
		off == `FCIC_OFF_CR0 && i_bus.wdata[`FCIC_CR0_RESET_BIT] &&
		!busy_q[0] && !pin_reset && !global_reset_bit_start;
	sequence s_reset_busy;
		busy_q[0] [*8];
	endsequence
	sequence s_reset_done;
		##[1:743] !busy_q[0];
	endsequence
	property p_reset_len;
		f0_cr0_reset_wr |=> s_reset_busy ##0 s_reset_done;
	endproperty
	a_reset_len: assert property (p_reset_len) // R5
		else $error("framer reset did not finish in time");
	property p_reset_read;
		g_rd && off == `FCIC_OFF_CR0 |=> o_rdata[7] == $past(busy_q[0]);
	endproperty
	a_reset_read: assert property (p_reset_read) // R6
		else $error("reset bit read wrong");
	property p_pin_reset;
		pin_reset |=> busy_q[0] && global_reset_bit_busy_q ##1 o_sysbus_oe_n[0];
	endproperty
	a_pin_reset: assert property (p_pin_reset) // R8
		else $error("pin reset did not start reset");
	property p_defaults;
		busy_q[0] |=> oe_n_q[0] && !rate_q[0] && mode_q[0] == 4'h0;
	endproperty
	a_defaults: assert property (p_defaults) // R9
		else $error("framer not at defaults during reset");
	property p_mir_latch;
		(|irr_vec[0]) && mie_q[0] |=> mir_q[0] ##1 !o_interrupt_pin_n;
	endproperty
	a_mir_latch: assert property (p_mir_latch) // R2
		else $error("master request not latched");
	property p_mie_block;
		!mie_q[0] |=> !mir_q[0];
	endproperty
	a_mie_block: assert property (p_mie_block) // R3
		else $error("master enable did not block");
	property p_pin_idle;
		mir_q == 8'h00 |=> o_interrupt_pin_n;
	endproperty
	a_pin_idle: assert property (p_pin_idle) // R23
		else $error("interrupt pin active without request");
	property p_irr_set;
		|(i_events[0][7] & ier_q[0][7]) |=> irr_q[0][7];
	endproperty
	a_irr_set: assert property (p_irr_set) // R16
		else $error("request bit not set by event");
	property p_irr_clear;
		i_bus.rd && fsel == 3'h0 && off == `FCIC_OFF_ISR_FIRST &&
			i_events[0][7] == 8'h00 |=> !irr_q[0][7] && isr_q[0][7] == 8'h00;
	endproperty
	a_irr_clear: assert property (p_irr_clear) // R17
		else $error("status read did not clear request");
	property p_crc_e1;
		incf_q[0] |=> cfg_q[0].crc_fbit_real == $past(rate_q[0]);
	endproperty
	a_crc_e1: assert property (p_crc_e1) // R10
		else $error("crc include does not follow line rate");
endmodule // fcic_top

// [test_framer_control_and_irq_hierarchy.sv]
// testbench of the framer control and interrupt hierarchy
`timescale 1ns/10ps
module test_framer_control_and_irq_hierarchy;
	import fcic_pkg::*;
	logic i_clock = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_rst_pin_n = 1'b1;
	fcic_bus_t bus;
	fcic_events_t ev = '0;
	logic [7:0] rdata;
	logic pin_n;
	logic [1:0] grp;
	logic [7:0] oe_n;
	logic [7:0] busy;
	logic onesec;
	logic test_en;
	logic [7:0] pio_n;
	fcic_cfg_t [7:0] cfg;
	int mismatches = 0;
	int checked = 0;
	logic [7:0] q;
	logic [7:0] v;
	int n;
	int f;
	int b;
	int s;

	always #10 i_clock = ~i_clock;

	fcic_host host (.i_clock(i_clock), .i_rdata(rdata), .o_bus(bus));

	fcic_top dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
		.i_rst_pin_n(i_rst_pin_n), .i_bus(bus), .i_events(ev),
		.o_rdata(rdata), .o_interrupt_pin_n(pin_n),
		.o_bus_group_mode(grp), .o_onesec_output(onesec),
		.o_test_enable(test_en), .o_sysbus_oe_n(oe_n),
		.o_pio_oe_n(pio_n), .o_reset_busy(busy),
		.o_cfg(cfg));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	function automatic logic [11:0] ad(input int fr, input logic [8:0] off);
		return {fr[2:0], off};
	endfunction

	function automatic logic [7:0] bit_of(input int k);
		return 8'h01 << k;
	endfunction

	function automatic fcic_t1_mode_t t1_exp(input logic [7:0] c);
		if (!c[0])
			return FCIC_T1_NONE;
		case (c[4:1])
			4'h0: return FCIC_T1_FT_ONLY;
			4'h1: return FCIC_T1_ESF_FPS;
			4'h4: return FCIC_T1_SF;
			4'h5: return FCIC_T1_SF_JAPANESE_YELLOW;
			4'h6: return FCIC_T1_SF_DATA_MUX;
			4'h8: return FCIC_T1_LOOP_FRAME_SLIP_LOSS;
			4'h9: return FCIC_T1_LOOP_CARRIER;
			4'hC: return FCIC_T1_ESF_MIMIC_CRC;
			4'hD: return FCIC_T1_ESF_FORCE_CRC;
			default: return FCIC_T1_RESERVED;
		endcase
	endfunction

	task results;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#400000;
		mismatches++;
		results;
	end

	initial begin
		void'($urandom(32'h2EE3E5C8));
		repeat (20) @(posedge i_clock);
		#1 i_sys_rst = 1'b0;
		chk(busy, 8'hFF);
		chk(oe_n, 8'hFF);
		chk(pio_n, 8'hFF);
		host.wait_idle(ad(0, 9'h080), n);
		host.wait_idle(ad(0, 9'h001), n);
		chk({7'h0, n < 800}, 8'h01);
		host.rd(ad(0, 9'h082), q);
		chk(q, 8'h00);
		$display("reset test done");

		for (f = 0; f < 8; f++) begin
			v = (f == 0) ? 8'h3E : (f == 1) ? 8'h1B :
				8'($urandom & 8'h3F);
			host.wr(ad(f, 9'h001), v);
			host.rd(ad(f, 9'h001), q);
			chk(q, v);
			chk({6'h0, cfg[f].line_rate_select, cfg[f].crc_fbit_real},
				{6'h0, v[0], v[0] & v[5]});
			chk({4'h0, cfg[f].rx_framer_mode}, {4'h0, v[4:1]});
			if (!v[0])
				chk({5'h0, cfg[f].e1_cas, cfg[f].e1_crc,
					cfg[f].bit_slip_search}, {5'h0, v[4:2]});
			chk({4'h0, cfg[f].t1_mode}, {4'h0, t1_exp(v)});
		end
		$display("config test done");

		for (f = 0; f < 8; f++) begin
			b = (f == 0) ? 7 : $urandom_range(7);
			s = $urandom_range(7);
			host.wr(ad(0, 9'h082), f[0] ? 8'h00 : 8'hFF);
			host.wr(ad(f, 9'(19 - b)), bit_of(s));
			@(posedge i_clock);
			#1 ev[f][b][s] = 1'b1;
			@(posedge i_clock);
			#1 ev[f][b][s] = 1'b0;
			repeat (3) @(posedge i_clock);
			#1;
			chk({7'h0, pin_n}, {7'h0, f[0]});
			host.rd(ad(0, 9'h081), q);
			chk(q, f[0] ? 8'h00 : bit_of(f));
			host.rd(ad(f, 9'h003), q);
			chk(q, bit_of(b));
			host.rd(ad(f, 9'(11 - b)), q);
			chk(q, bit_of(s));
			host.rd(ad(f, 9'(11 - b)), q);
			chk(q, 8'h00);
			host.rd(ad(f, 9'h003), q);
			chk(q, 8'h00);
			host.rd(ad(0, 9'h081), q);
			chk(q, 8'h00);
			chk({7'h0, pin_n}, 8'h01);
		end
		$display("interrupt test done");

		for (int k = 0; k < 2; k++) begin
			f = k ? $urandom_range(7) : 0;
			host.wr(ad(f, 9'h001), 8'h80);
			host.rd(ad(f, 9'h001), q);
			chk(q, 8'h80);
			chk({6'h0, oe_n[f], pio_n[f]}, 8'h03);
			host.wait_idle(ad(f, 9'h001), n);
			chk({7'h0, n >= 370 && n <= 375}, 8'h01);
		end
		$display("framer reset test done");

		v = 8'($urandom & 8'h07);
		host.wr(ad(0, 9'h080), v);
		host.rd(ad(0, 9'h080), q);
		chk(q, v);
		chk({5'h0, onesec, grp}, {5'h0, v[2:0]});
		host.wr(ad(0, 9'h082), 8'hA5);
		host.wr(ad(0, 9'h083), 8'h02);
		host.rd(ad(0, 9'h082), q);
		chk(q, 8'hA5);
		chk({7'h0, test_en}, 8'h01);
		host.wr(ad(0, 9'h080), 8'h80);
		host.rd(ad(0, 9'h082), q);
		chk(q, 8'h00);
		chk(busy, 8'hFF);
		host.wait_idle(ad(0, 9'h080), n);
		host.rd(ad(0, 9'h080), q);
		chk(q, 8'h00);
		chk({6'h0, onesec, test_en}, 8'h00);
		$display("global reset test done");

		i_rst_pin_n = 1'b0;
		repeat (4) @(posedge i_clock);
		#1 chk(busy, 8'hFF);
		i_rst_pin_n = 1'b1;
		host.wait_idle(ad(0, 9'h001), n);
		chk({7'h0, n < 800}, 8'h01);
		$display("reset pin test done");
		results;
	end
endmodule // test_framer_control_and_irq_hierarchy
